//--- design/flash_host_pkg.sv
// Purpose: shared constants, types and decode functions for the serial flash host controller
// Assumes: reference clock of 20 MHz, serial clock idle low, data launched on falling edges
// Notes:   opcodes, address layout and timing counts are defined here; the controller assertions repeat 36h and 39h as literals
package flash_host_pkg;

    // reference clock and derived serial clock timing
    localparam int CLK_PERIOD_NS  = 50;
    localparam int SCLK_PERIOD_NS = 400;
    localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int CS_HIGH_NS     = 100;
    localparam int CS_HIGH_CYC    = (CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // instruction codes
    localparam logic [7:0] OPC_PARAM_READ = 8'h5a;
    localparam logic [7:0] OPC_SEC_ERASE  = 8'h44;
    localparam logic [7:0] OPC_SEC_PROG   = 8'h42;
    localparam logic [7:0] OPC_SEC_READ   = 8'h48;
    localparam logic [7:0] OPC_BLK_LOCK   = 8'h36;
    localparam logic [7:0] OPC_BLK_UNLOCK = 8'h39;
    localparam logic [7:0] OPC_WR_ENABLE  = 8'h06;
    localparam logic [7:0] OPC_RD_STATUS  = 8'h05;
    localparam logic [7:0] DUMMY_BYTE     = 8'h00;

    // frame shapes, counted in bytes
    localparam logic [2:0] HDR_LEN_WRITE  = 3'd4;
    localparam logic [2:0] HDR_LEN_READ   = 3'd5;
    localparam logic [2:0] HDR_LEN_WREN   = 3'd1;
    localparam logic [2:0] HDR_LEN_POLL   = 3'd2;
    localparam logic [8:0] MAX_XFER_LEN   = 9'h100;
    localparam int         STATUS_BUSY_BIT = 0;

    // security register and parameter read address fields
    localparam logic [1:0] SEC_SEL_NONE   = 2'h0;
    localparam logic [7:0] SEC_ADDR_TOP   = 8'h00;
    localparam logic [3:0] SEC_ADDR_MID   = 4'h0;
    localparam logic [15:0] PARAM_ADDR_TOP = 16'h0000;

    // reset values
    localparam logic [7:0] BYTE_RESET     = 8'h00;
    localparam logic [8:0] COUNT_RESET    = 9'h000;

    typedef enum logic [2:0] {
        OP_PARAM_READ = 3'h0,
        OP_SEC_ERASE  = 3'h1,
        OP_SEC_PROG   = 3'h2,
        OP_SEC_READ   = 3'h3,
        OP_BLK_LOCK   = 3'h4,
        OP_BLK_UNLOCK = 3'h5
    } user_op_t;

    typedef struct packed {
        user_op_t    op;
        logic [1:0]  sec_sel;
        logic [23:0] addr;
        logic [8:0]  len;
    } cmd_t;

    typedef struct packed {
        logic done;
        logic err;
    } result_t;

    function automatic logic [7:0] opcode_of(input user_op_t op);
        case (op)
            OP_PARAM_READ: opcode_of = OPC_PARAM_READ;
            OP_SEC_ERASE:  opcode_of = OPC_SEC_ERASE;
            OP_SEC_PROG:   opcode_of = OPC_SEC_PROG;
            OP_SEC_READ:   opcode_of = OPC_SEC_READ;
            OP_BLK_LOCK:   opcode_of = OPC_BLK_LOCK;
            OP_BLK_UNLOCK: opcode_of = OPC_BLK_UNLOCK;
            default:       opcode_of = OPC_RD_STATUS;
        endcase
    endfunction : opcode_of

    function automatic logic is_write_op(input user_op_t op);
        is_write_op = (op == OP_SEC_ERASE) || (op == OP_SEC_PROG) ||
                      (op == OP_BLK_LOCK) || (op == OP_BLK_UNLOCK);
    endfunction : is_write_op

    function automatic logic is_read_op(input user_op_t op);
        is_read_op = (op == OP_PARAM_READ) || (op == OP_SEC_READ);
    endfunction : is_read_op

    function automatic logic is_sec_op(input user_op_t op);
        is_sec_op = (op == OP_SEC_ERASE) || (op == OP_SEC_PROG) || (op == OP_SEC_READ);
    endfunction : is_sec_op

endpackage : flash_host_pkg

//--- design/flash_host_sclk.sv
// Purpose: serial clock divider with edge ticks
// Assumes: clock idles low while run is low
// Notes:   each run starts with a full low phase so data set up before run is stable
`timescale 1ns/10ps
module flash_host_sclk #(
    parameter int HALF = 4
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic run,
    output logic      sclk,
    output logic      rise_tick,
    output logic      fall_tick
);
    logic [7:0] cnt_r;
    logic       sclk_r;
    logic       wrap;

    assign wrap      = run && (cnt_r == 8'(HALF - 1));
    assign rise_tick = wrap && !sclk_r;
    assign fall_tick = wrap && sclk_r;
    assign sclk      = sclk_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= 8'h00;
        end else if (ce) begin
            if (!run || wrap) begin
                cnt_r <= 8'h00;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_r <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                sclk_r <= 1'b0;
            end else if (wrap) begin
                sclk_r <= !sclk_r;
            end
        end
    end
endmodule : flash_host_sclk

//--- design/flash_host_buf.sv
// Purpose: small valid/ready buffer for read data
// Assumes: one push and one pop per cycle at most each
// Notes:   output data comes straight from storage registers
`timescale 1ns/10ps
module flash_host_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_r;
    logic [PW-1:0]    rd_ptr_r;
    logic [PW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready  = (count_r != (PW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_r];

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else if (ce) begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_r <= '0;
        end else if (ce) begin
            case ({push, pop})
                2'b10:   count_r <= count_r + 1'b1;
                2'b01:   count_r <= count_r - 1'b1;
                default: count_r <= count_r;
            endcase
        end
    end
endmodule : flash_host_buf

//--- design/flash_host_ctrl.sv
// Purpose: host controller issuing parameter-table, security register and block lock commands to a serial flash
// Assumes: single-bit mode 0 serial link; serial clock made here by dividing REF_CLK
// Notes:   write-type commands get an automatic write enable frame; erase and program poll busy to completion
`timescale 1ns/10ps

// Summary of operation
// - parameter read: 5Ah, address, dummy, then data
// - parameter read address bits 23-8 are zero
// - security address selects register one to three
// - security erase 44h needs write enable first
// - chip select rises right after address byte
// - program 42h, address, 1-256 bytes, write enable
// - chip select held low through program data
// - security read 48h, address, eight dummy clocks
// - block lock 36h with address, needs enable
// - block unlock 39h with address, needs enable
module flash_host_ctrl
    import flash_host_pkg::*;
(
    input  wire logic       REF_CLK,
    input  wire logic       RST_N,
    input  wire logic       CLK_EN,
    input  wire cmd_t       CMD,
    input  wire logic       CMD_VALID,
    output logic            CMD_READY,
    input  wire logic [7:0] WR_DATA,
    input  wire logic       WR_VALID,
    output logic            WR_READY,
    output logic [7:0]      RD_DATA,
    output logic            RD_VALID,
    input  wire logic       RD_READY,
    output result_t         RESULT,
    output logic            SPI_CS_N,
    output logic            SPI_SCLK,
    output logic            SERIAL_DATA_IN,
    input  wire logic       SERIAL_DATA_OUT
);
    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_WREN  = 8'h02,
        ST_GAP   = 8'h04,
        ST_CMD   = 8'h08,
        ST_WDATA = 8'h10,
        ST_RDATA = 8'h20,
        ST_POLL  = 8'h40,
        ST_DONE  = 8'h80
    } state_t;

    state_t      state_r;
    state_t      state_nxt;
    state_t      after_gap_r;
    user_op_t    op_r;
    logic [23:0] addr_r;
    logic [8:0]  len_r;
    logic [8:0]  data_cnt_r;
    logic [2:0]  byte_cnt_r;
    logic [7:0]  gap_cnt_r;
    logic        cs_n_r;
    logic        err_r;
    logic        done_r;
    logic        dev_busy_r;
    logic        wren_seen_r;

    // byte shifter
    logic        busy_r;
    logic [2:0]  bit_cnt_r;
    logic [7:0]  tx_sr_r;
    logic [7:0]  rx_sr_r;
    logic        mosi_r;
    logic        start_byte;
    logic [7:0]  start_data;
    logic        byte_done;
    logic [7:0]  rx_byte;
    logic        rise_tick;
    logic        fall_tick;

    // device output synchroniser
    logic        miso_meta_r;
    logic        miso_s_r;

    logic        cmd_ok;
    logic        buf_in_ready;
    logic [2:0]  hdr_len;
    logic        hdr_sent;

    flash_host_sclk #(
        .HALF (SCLK_HALF_CYC)
    ) u_sclk (
        .clk       (REF_CLK),
        .rst_n     (RST_N),
        .ce        (CLK_EN),
        .run       (busy_r),
        .sclk      (SPI_SCLK),
        .rise_tick (rise_tick),
        .fall_tick (fall_tick)
    );

    flash_host_buf #(
        .WIDTH (8),
        .DEPTH (2)
    ) u_rd_buf (
        .clk       (REF_CLK),
        .rst_n     (RST_N),
        .ce        (CLK_EN),
        .in_data   (rx_byte),
        .in_valid  (byte_done && (state_r == ST_RDATA)),
        .in_ready  (buf_in_ready),
        .out_data  (RD_DATA),
        .out_valid (RD_VALID),
        .out_ready (RD_READY)
    );

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            miso_meta_r <= 1'b0;
            miso_s_r    <= 1'b0;
        end else if (CLK_EN) begin
            miso_meta_r <= SERIAL_DATA_OUT;
            miso_s_r    <= miso_meta_r;
        end
    end

    assign SPI_CS_N       = cs_n_r;
    assign SERIAL_DATA_IN = mosi_r;
    assign RESULT         = '{done: done_r, err: err_r};
    assign CMD_READY      = (state_r == ST_IDLE);
    assign byte_done      = busy_r && fall_tick && (bit_cnt_r == 3'd7);
    assign rx_byte        = {rx_sr_r[6:0], miso_s_r};

    // command validity: zero or oversize read and program lengths and an empty security register select are refused
    always_comb begin
        cmd_ok = 1'b1;
        if (is_sec_op(CMD.op) && (CMD.sec_sel == SEC_SEL_NONE)) begin
            cmd_ok = 1'b0;
        end
        if ((is_read_op(CMD.op) || (CMD.op == OP_SEC_PROG)) &&
            ((CMD.len == COUNT_RESET) || (CMD.len > MAX_XFER_LEN))) begin
            cmd_ok = 1'b0;
        end
        if (CMD.op > OP_BLK_UNLOCK) begin
            cmd_ok = 1'b0;
        end
    end

    always_comb begin
        case (state_r)
            ST_WREN: hdr_len = HDR_LEN_WREN;
            ST_POLL: hdr_len = HDR_LEN_POLL;
            ST_CMD:  hdr_len = is_read_op(op_r) ? HDR_LEN_READ : HDR_LEN_WRITE;
            default: hdr_len = 3'd0;
        endcase
    end
    assign hdr_sent = !busy_r && (byte_cnt_r == hdr_len);

    // next byte to shift and when to start it
    always_comb begin
        start_byte = 1'b0;
        start_data = DUMMY_BYTE;
        case (state_r)
            ST_WREN: begin
                start_byte = !busy_r && (byte_cnt_r == 3'd0);
                start_data = OPC_WR_ENABLE;
            end
            ST_POLL: begin
                start_byte = !busy_r && (byte_cnt_r < HDR_LEN_POLL);
                start_data = (byte_cnt_r == 3'd0) ? OPC_RD_STATUS : DUMMY_BYTE;
            end
            ST_CMD: begin
                start_byte = !busy_r && (byte_cnt_r < hdr_len);
                case (byte_cnt_r)
                    3'd0:    start_data = opcode_of(op_r);
                    3'd1:    start_data = addr_r[23:16];
                    3'd2:    start_data = addr_r[15:8];
                    3'd3:    start_data = addr_r[7:0];
                    default: start_data = DUMMY_BYTE;
                endcase
            end
            ST_WDATA: begin
                start_byte = WR_VALID && WR_READY;
                start_data = WR_DATA;
            end
            ST_RDATA: begin
                // only start a byte when the buffer can take it, so no word is lost
                start_byte = !busy_r && (data_cnt_r < len_r) && buf_in_ready;
                start_data = DUMMY_BYTE;
            end
            default: begin
                start_byte = 1'b0;
                start_data = DUMMY_BYTE;
            end
        endcase
    end

    // program data pauses the clock rather than releasing chip select
    assign WR_READY = (state_r == ST_WDATA) && !busy_r && (data_cnt_r < len_r);

    // bit shifter: launch on falling edge, sample late in the high phase
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            busy_r    <= 1'b0;
            bit_cnt_r <= 3'd0;
            tx_sr_r   <= BYTE_RESET;
            rx_sr_r   <= BYTE_RESET;
            mosi_r    <= 1'b0;
        end else if (CLK_EN) begin
            if (start_byte) begin
                busy_r    <= 1'b1;
                bit_cnt_r <= 3'd0;
                mosi_r    <= start_data[7];
                tx_sr_r   <= {start_data[6:0], 1'b0};
            end else if (busy_r && fall_tick) begin
                rx_sr_r <= rx_byte;
                if (bit_cnt_r == 3'd7) begin
                    busy_r <= 1'b0;
                end else begin
                    bit_cnt_r <= bit_cnt_r + 3'd1;
                    mosi_r    <= tx_sr_r[7];
                    tx_sr_r   <= {tx_sr_r[6:0], 1'b0};
                end
            end
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (CMD_VALID) begin
                    state_nxt = !cmd_ok ? ST_DONE : (is_write_op(CMD.op) ? ST_WREN : ST_CMD);
                end
            end
            ST_WREN: state_nxt = hdr_sent ? ST_GAP : ST_WREN;
            ST_CMD: begin
                if (hdr_sent) begin
                    if (op_r == OP_SEC_PROG) begin
                        state_nxt = ST_WDATA;
                    end else if (is_read_op(op_r)) begin
                        state_nxt = ST_RDATA;
                    end else begin
                        state_nxt = ST_GAP;
                    end
                end
            end
            ST_WDATA: state_nxt = (!busy_r && (data_cnt_r == len_r)) ? ST_GAP : ST_WDATA;
            ST_RDATA: state_nxt = (!busy_r && (data_cnt_r == len_r)) ? ST_GAP : ST_RDATA;
            ST_POLL:  state_nxt = hdr_sent ? ST_GAP : ST_POLL;
            ST_GAP:   state_nxt = (gap_cnt_r >= 8'(CS_HIGH_CYC - 1)) ? after_gap_r : ST_GAP;
            ST_DONE:  state_nxt = ST_IDLE;
            default:  state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            state_r <= ST_IDLE;
        end else if (CLK_EN) begin
            state_r <= state_nxt;
        end
    end

    // where to go once chip select has been high long enough
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            after_gap_r <= ST_IDLE;
        end else if (CLK_EN && (state_nxt == ST_GAP) && (state_r != ST_GAP)) begin
            case (state_r)
                ST_WREN:  after_gap_r <= ST_CMD;
                ST_WDATA: after_gap_r <= ST_POLL;
                ST_CMD:   after_gap_r <= (op_r == OP_SEC_ERASE) ? ST_POLL : ST_DONE;
                ST_POLL:  after_gap_r <= dev_busy_r ? ST_POLL : ST_DONE;
                default:  after_gap_r <= ST_DONE;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            cs_n_r <= 1'b1;
        end else if (CLK_EN) begin
            if ((state_nxt == ST_GAP) || (state_nxt == ST_DONE) || (state_nxt == ST_IDLE)) begin
                cs_n_r <= 1'b1;
            end else begin
                cs_n_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            gap_cnt_r  <= 8'h00;
            byte_cnt_r <= 3'd0;
            data_cnt_r <= COUNT_RESET;
        end else if (CLK_EN) begin
            gap_cnt_r <= (state_r == ST_GAP) ? gap_cnt_r + 8'h01 : 8'h00;
            if (state_r == ST_GAP || state_r == ST_IDLE) begin
                byte_cnt_r <= 3'd0;
                data_cnt_r <= COUNT_RESET;
            end else if (start_byte) begin
                if (state_r == ST_WDATA || state_r == ST_RDATA) begin
                    data_cnt_r <= data_cnt_r + 9'h001;
                end else begin
                    byte_cnt_r <= byte_cnt_r + 3'd1;
                end
            end
        end
    end

    // command capture and address shaping
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            op_r   <= OP_PARAM_READ;
            addr_r <= 24'h000000;
            len_r  <= COUNT_RESET;
        end else if (CLK_EN && CMD_VALID && CMD_READY) begin
            op_r  <= CMD.op;
            len_r <= CMD.len;
            if (CMD.op == OP_PARAM_READ) begin
                addr_r <= {PARAM_ADDR_TOP, CMD.addr[7:0]};
            end else if (is_sec_op(CMD.op)) begin
                addr_r <= {SEC_ADDR_TOP, 2'b00, CMD.sec_sel, SEC_ADDR_MID, CMD.addr[7:0]};
            end else begin
                addr_r <= CMD.addr;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            done_r      <= 1'b0;
            err_r       <= 1'b0;
            wren_seen_r <= 1'b0;
            dev_busy_r  <= 1'b0;
        end else if (CLK_EN) begin
            done_r <= (state_r == ST_DONE);
            if (CMD_VALID && CMD_READY) begin
                err_r <= !cmd_ok;
            end
            if (state_r == ST_IDLE) begin
                wren_seen_r <= 1'b0;
            end else if (state_r == ST_WREN && byte_done) begin
                wren_seen_r <= 1'b1;
            end
            if (state_r == ST_POLL && byte_done && byte_cnt_r == HDR_LEN_POLL) begin
                dev_busy_r <= rx_byte[STATUS_BUSY_BIT];
            end
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_erase_last_addr;
        (state_r == ST_CMD) && (op_r == OP_SEC_ERASE) && byte_done && (byte_cnt_r == HDR_LEN_WRITE);
    endsequence

    sequence s_cs_up_now;
        ##2 (cs_n_r && state_r == ST_GAP);
    endsequence

    a_param_addr_top: assert property ((state_r == ST_CMD && op_r == OP_PARAM_READ) |-> addr_r[23:8] == 16'h0000)
        else $error("parameter read high address not zero");
    a_sec_addr_form: assert property ((state_r == ST_CMD && is_sec_op(op_r)) |->
        (addr_r[23:16] == 8'h00 && addr_r[11:8] == 4'h0 && addr_r[15:12] >= 4'h1 && addr_r[15:12] <= 4'h3))
        else $error("security address malformed");
    a_erase_cs_rise: assert property (s_erase_last_addr |-> s_cs_up_now)
        else $error("chip select not raised after erase address");
    a_write_after_wren: assert property ((state_r == ST_CMD && start_byte && byte_cnt_r == 3'd0 &&
        is_write_op(op_r)) |-> wren_seen_r)
        else $error("write command without write enable frame");
    a_prog_cs_low: assert property ((state_r == ST_WDATA) |-> !cs_n_r)
        else $error("chip select released during program data");
    a_read_after_dummy: assert property ($rose(state_r == ST_RDATA) |-> byte_cnt_r == HDR_LEN_READ)
        else $error("read data phase before 40 clocks");
    a_mosi_rise_stable: assert property (rise_tick |=> $stable(mosi_r))
        else $error("data changed around rising serial clock");
    a_prog_len_cap: assert property ((state_r == ST_WDATA) |-> (data_cnt_r <= MAX_XFER_LEN && len_r != 9'h000))
        else $error("program length outside 1 to 256");
    a_lock_opcode: assert property ((state_r == ST_CMD && op_r == OP_BLK_LOCK && start_byte &&
        byte_cnt_r == 3'd0) |-> start_data == 8'h36)
        else $error("block lock opcode wrong");
    a_unlock_opcode: assert property ((state_r == ST_CMD && op_r == OP_BLK_UNLOCK && start_byte &&
        byte_cnt_r == 3'd0) |-> start_data == 8'h39)
        else $error("block unlock opcode wrong");

endmodule : flash_host_ctrl

//--- sim/flash_dev_model.sv
// Purpose: behavioural serial flash for the host controller bench
// Assumes: mode 0, one data line
// Notes:   data line toggles when deselected
`timescale 1ns/10ps
module flash_dev_model (input logic cs_n, sclk, di, output logic do_o);
    logic [7:0]  sh, op, ob, mem [1024], lck [256];
    logic [23:0] a;
    logic        write_enable_latch = 0, busy = 0;
    logic [3:0]  slb = 4'h0; // security register one-time lock bits, none set
    int          n;
    initial begin
        do_o = 0;
        foreach (mem[i]) mem[i] = 8'h00;
        foreach (lck[i]) lck[i] = 8'h01;
    end
    always @(negedge cs_n) n = 0;
    always @(posedge sclk) begin
        sh = {sh[6:0], di};
        n++;
        if (n == 8) op = sh;
        if (n > 8 && n <= 32) a = {a[22:0], di};
        if (op == 8'h42 && write_enable_latch && !slb[a[13:12]] && n > 32 && n % 8 == 0) begin
            mem[{a[13:12], a[7:0]}] &= sh;
            a[7:0]++;
        end
        if ((op == 8'h48 || op == 8'h5a) && n > 40 && n % 8 == 0) a[7:0]++;
    end
    always @(negedge sclk) begin
        ob = (op == 8'h05) ? {6'h0, write_enable_latch, busy} : (op == 8'h48) ? mem[{a[13:12], a[7:0]}] : a[7:0] ^ 8'h5a;
        if (n >= 8) do_o = ob[7 - n % 8];
    end
    // rejected writes fall through untouched
    always @(posedge cs_n) begin
        do_o = ~do_o;
        if (op == 8'h06 && n == 8) write_enable_latch = 1;
        if (write_enable_latch && n == 32 && (op == 8'h36 || op == 8'h39)) begin
            lck[a[23:16]] = {7'h0, op == 8'h36};
            write_enable_latch = 0;
        end
        if (op == 8'h42 && write_enable_latch) write_enable_latch = 0;
        if (op == 8'h44 && write_enable_latch && !slb[a[13:12]] && n == 32) begin
            busy = 1;
            for (int i = 0; i < 256; i++) mem[{a[13:12], i[7:0]}] = 8'hff;
            fork begin #3000 busy = 0; write_enable_latch = 0; end join_none
        end
    end
endmodule : flash_dev_model

//--- sim/tb_top.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: behavioural device on the serial pins
// Notes:   inputs change on falling edges
`timescale 1ns/10ps
module tb_top import flash_host_pkg::*;;
    logic       clk = 0, rst_n = 0, cv = 0, wv = 0, rr = 0, hw, hr;
    logic [7:0] wd = 0, rs, rd, q[$], wq[$];
    logic       cr, wr, rv, cs_n, sclk, di, do_o;
    cmd_t       cmd = '0;
    result_t    res;
    int         errors = 0, n_checks = 0;
    flash_host_ctrl dut (.REF_CLK(clk), .RST_N(rst_n), .CLK_EN(1'b1), .CMD(cmd), .CMD_VALID(cv),
        .CMD_READY(cr), .WR_DATA(wd), .WR_VALID(wv), .WR_READY(wr), .RD_DATA(rd), .RD_VALID(rv),
        .RD_READY(rr), .RESULT(res), .SPI_CS_N(cs_n), .SPI_SCLK(sclk), .SERIAL_DATA_IN(di),
        .SERIAL_DATA_OUT(do_o));
    flash_dev_model dev (.cs_n(cs_n), .sclk(sclk), .di(di), .do_o(do_o));
    initial forever #25 clk = ~clk;
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    task automatic chk(input logic [7:0] g, input logic [7:0] w);
        n_checks++;
        if (g !== w) begin
            errors++;
            $display("mismatch t=%0t got %h exp %h", $time, g, w);
        end
    endtask : chk
    // consumer stalls for 600 cycles so the read buffer fills up
    task automatic run(input user_op_t op, input logic [1:0] s, input logic [23:0] a,
                       input logic [8:0] n, input logic e);
        int t;
        logic d;
        t = 0;
        d = 0;
        hw = 0;
        hr = 0;
        q = {};
        @(negedge clk);
        cmd = '{op, s, a, n};
        cv = 1;
        @(negedge clk);
        cv = 0;
        // keep draining the read buffer after done until it is empty
        while (!(d && !rv && !hr) && t < 20000) begin
            if (hw) void'(wq.pop_front());
            if (hr) q.push_back(rs);
            wv = wq.size() > 0;
            wd = wv ? wq[0] : 8'h00;
            rr = t > 600;
            #1 hw = wv && wr;
            hr = rv && rr;
            rs = rd;
            @(negedge clk);
            t++;
            if (res.done === 1'b1) d = 1;
        end
        chk({7'h0, d}, 8'h01);
        chk({7'h0, res.err}, {7'h0, e});
    endtask : run
    task automatic t_param;
        run(OP_PARAM_READ, 2'h0, 24'h0000fe, 9'h002, 1'b0);
        chk(dev.op, 8'h5a);
        chk(dev.a[15:8], 8'h00);
        chk(q[0], 8'hfe ^ 8'h5a);
        chk(q[1], 8'hff ^ 8'h5a);
    endtask : t_param
    task automatic t_sec;
        run(OP_SEC_ERASE, 2'h2, 24'h000000, 9'h001, 1'b0);
        chk(dev.mem[10'h2ff], 8'hff);
        chk({7'h0, dev.busy}, 8'h00);
        wq = {8'ha5, 8'h3c};
        run(OP_SEC_PROG, 2'h2, 24'h0000ff, 9'h002, 1'b0);
        run(OP_SEC_READ, 2'h2, 24'h0000ff, 9'h003, 1'b0);
        chk(dev.a[15:8], 8'h20);
        chk(q[0], 8'ha5);
        chk(q[1], 8'h3c);
        chk(q[2], 8'hff);
    endtask : t_sec
    task automatic t_lock;
        chk(dev.lck[8'h12], 8'h01);
        run(OP_BLK_UNLOCK, 2'h0, 24'h123456, 9'h001, 1'b0);
        chk(dev.lck[8'h12], 8'h00);
        run(OP_BLK_LOCK, 2'h0, 24'h123456, 9'h001, 1'b0);
        chk(dev.lck[8'h12], 8'h01);
    endtask : t_lock
    task automatic t_bad;
        run(OP_SEC_READ, 2'h0, 24'h000000, 9'h001, 1'b1);
        run(OP_SEC_PROG, 2'h1, 24'h000000, 9'h000, 1'b1);
    endtask : t_bad
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1;
        t_param;
        t_sec;
        t_lock;
        t_bad;
        final_report;
    end
    initial begin
        #3000000;
        errors++;
        final_report;
    end
endmodule : tb_top
